// ===== logic/ibw_bit_timing.sv
// Bit timing, clock stretching and bus watch timer of the bit-level two-wire interface
//
// Behaviour
// - A controller request raised during a busy bus waits for a stop condition or a bus time-out.
// - The transmit bit reaches SDA only while SCL is low.
// - SCL low phase is stretched while a bit event awaits the service routine.
// - Data ready is signalled at every SCL rising edge while the interface is enabled.
// - Minimum SCL high and low times equal selected machine cycles of six clocks.
// - The bus watch timer reloads at every SCL transition while operating.
// - Reload value is eight minus minimum count; minimum time done at count eight.
// - All enables off: interface disabled; timer cleared and stopped if timer run off.
// - Enabled without timer run: only three low timer bits count, no hung check.
// - Enabled with timer run: full timer counts in frames, reloaded by edges, cleared by start, stop.
// - Selector 10/01/00/11 gives minimum counts 7/6/5/4, also as controller.
// - Time-out periods are 1023/1022/1021/1020 machine cycles for 10/01/00/11.
// - Target enable is cleared by reset and by a bus time-out.
// - Controller role set when requested and bus idle; cleared by loss, or by the next stop after a stop command given with the request off.
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "ibw_map.svh"

module ibw_bit_timing (
	input  wire logic        aclk,            // System clock, 50 MHz
	input  wire logic        aresetn,         // Synchronous reset, active low
	input  wire logic [7:0]  s_axi_awaddr,    // Write address
	input  wire logic        s_axi_awvalid,   // Write address valid
	output logic             s_axi_awready,   // Write address ready
	input  wire logic [31:0] s_axi_wdata,     // Write data
	input  wire logic [3:0]  s_axi_wstrb,     // Write byte strobes
	input  wire logic        s_axi_wvalid,    // Write data valid
	output logic             s_axi_wready,    // Write data ready
	output logic [1:0]       s_axi_bresp,     // Write response
	output logic             s_axi_bvalid,    // Write response valid
	input  wire logic        s_axi_bready,    // Write response ready
	input  wire logic [7:0]  s_axi_araddr,    // Read address
	input  wire logic        s_axi_arvalid,   // Read address valid
	output logic             s_axi_arready,   // Read address ready
	output logic [31:0]      s_axi_rdata,     // Read data
	output logic [1:0]       s_axi_rresp,     // Read response
	output logic             s_axi_rvalid,    // Read data valid
	input  wire logic        s_axi_rready,    // Read data ready
	input  wire logic        scl_in,          // SCL pin level
	output logic             scl_out,         // SCL output value, always low
	output logic             scl_oe,          // SCL pulled low while high
	input  wire logic        sda_in,          // SDA pin level
	output logic             sda_out,         // SDA output value, always low
	output logic             sda_oe,          // SDA pulled low while high
	input  wire logic        transmit_bit,    // Bit to place on SDA
	input  wire logic        transmit_active, // SDA may be driven low
	input  wire logic        event_pending,   // Bit event not yet serviced
	input  wire logic        arbitration_lost,// Pulse: arbitration lost
	input  wire logic        send_stop_cmd,   // Pulse: software asked for a stop
	output logic             data_ready_set,  // Pulse: SCL rising edge seen
	output logic             start_det,       // Pulse: start condition seen
	output logic             stop_det,        // Pulse: stop condition seen
	output logic             is_controller,   // Device holds the controller role
	output logic             bus_busy,        // Frame in progress on the bus
	output logic             min_time_ok,     // Minimum SCL phase time elapsed
	output logic             irq              // Level interrupt
);

	// All state of the block is one registered struct; s_next is its next value
	ibw_pkg::ibw_state_type s_reg;
	ibw_pkg::ibw_state_type s_next;

	// Minimum phase length in machine cycles for each selector code

	function automatic logic [3:0] min_count(input logic [1:0] sel);
		unique case (sel)
			2'b10: min_count = `IBW_MIN_COUNT_10;
			2'b01: min_count = `IBW_MIN_COUNT_01;
			2'b00: min_count = `IBW_MIN_COUNT_00;
			2'b11: min_count = `IBW_MIN_COUNT_11;
		endcase
	endfunction

	// Read view of the registers; unmapped offsets and reserved bits read zero
	function automatic logic [31:0] read_word(input ibw_pkg::ibw_state_type st,
	                                          input logic [7:0] addr);
		read_word = 32'h0000_0000;
		case (addr)
			`IBW_OFS_CONFIG: begin
				read_word[`IBW_CFG_TARGET_EN]   = st.cfg.target_enable;
				read_word[`IBW_CFG_MASTER_REQ]  = st.cfg.master_request;
				read_word[`IBW_CFG_TIMER_RUN]   = st.cfg.bus_timer_run;
				read_word[`IBW_CFG_MTS_HI]      = st.cfg.min_time_select[1];
				read_word[`IBW_CFG_MTS_LO]      = st.cfg.min_time_select[0];
			end
			`IBW_OFS_IRQ_STATUS: read_word[3:0] = st.status;
			`IBW_OFS_IRQ_MASK:   read_word[3:0] = st.mask;
			`IBW_OFS_STATE: begin
				read_word[`IBW_STATE_CTRL]   = st.is_controller;
				read_word[`IBW_STATE_BUSY]   = st.bus_busy;
				read_word[`IBW_STATE_MIN_OK] = st.min_ok;
				read_word[`IBW_STATE_TIMER_LSB +: `IBW_TIMER_W] = st.timer;
			end
			default: read_word = 32'h0000_0000;
		endcase
	endfunction

	// True for the four decoded offsets; anything else answers with an error
	function automatic logic mapped(input logic [7:0] addr);
		mapped = (addr == `IBW_OFS_CONFIG) || (addr == `IBW_OFS_IRQ_STATUS) ||
		         (addr == `IBW_OFS_IRQ_MASK) || (addr == `IBW_OFS_STATE);
	endfunction

	logic       scl;
	logic       scl_prev;
	logic       sda;
	logic       sda_prev;
	logic       scl_edge;
	logic       start_cond;
	logic       stop_cond;
	logic       enabled;
	logic       mc_tick;
	logic [3:0] low_sum;
	logic [10:0] full_sum;
	logic       do_write;
	logic [7:0] wbyte;
	ibw_pkg::ibw_events_type ev_set;
	ibw_pkg::ibw_events_type ev_clr;
	logic       clr_timeout;

	// Timing notes for the next engineer:
	// Both pins are sampled asynchronously, so edges and start or stop
	// conditions are seen three clocks after the pin moves. At 50 MHz this
	// lag is half of one machine cycle and does not disturb the minimum
	// phase times, but a test that watches pulses must allow for it.
	// Start and stop are only recognised while SCL was high in both of the
	// last two samples, so an SDA change that races an SCL fall is ignored.
	// The machine cycle divider runs free; the first tick after a reload
	// may therefore come up to five clocks early. The minimum times are
	// met to within one machine cycle, which the bus tolerates.
	always_comb begin
		s_next = s_reg;
		s_next.data_ready_set = 1'b0;
		s_next.start_det = 1'b0;
		s_next.stop_det = 1'b0;
		ev_set = '0;
		ev_clr = '0;
		clr_timeout = 1'b0;

		// Pins pass two flip-flops; the third stage keeps the previous level
		s_next.scl_sync = {s_reg.scl_sync[1:0], scl_in};
		s_next.sda_sync = {s_reg.sda_sync[1:0], sda_in};
		scl = s_reg.scl_sync[1];
		scl_prev = s_reg.scl_sync[2];
		sda = s_reg.sda_sync[1];
		sda_prev = s_reg.sda_sync[2];
		scl_edge = scl ^ scl_prev;
		start_cond = scl && scl_prev && sda_prev && !sda;
		stop_cond = scl && scl_prev && !sda_prev && sda;

		enabled = s_reg.cfg.target_enable || s_reg.cfg.master_request ||
		          s_reg.is_controller;

		mc_tick = (s_reg.mc_div == 3'(`IBW_MC_CLOCKS - 1));
		s_next.mc_div = mc_tick ? 3'h0 : 3'(s_reg.mc_div + 3'h1);

		low_sum = {1'b0, s_reg.timer[2:0]} + 4'h1;
		full_sum = {1'b0, s_reg.timer} + 11'h001;


		// Bus watch timer
		// The low three bits give the minimum phase time: carry out of bit 2
		// marks count eight. With timer run set and a frame open, all ten bits
		// count and the carry out of bit 9 is the hung bus time-out.
		// Without timer run only the low bits move, so no time-out can occur.
		if (!enabled && !s_reg.cfg.bus_timer_run) begin
			s_next.timer = '0;
			s_next.min_ok = 1'b0;
		end else if (!enabled) begin
			s_next.min_ok = 1'b0;
		end else if (scl_edge) begin
			s_next.timer = `IBW_RELOAD_BASE -
			               {6'h00, min_count(s_reg.cfg.min_time_select)};
			s_next.min_ok = 1'b0;
		end else if (s_reg.cfg.bus_timer_run && (start_cond || stop_cond)) begin
			s_next.timer = '0;
			s_next.min_ok = 1'b0;
		end else if (mc_tick) begin
			if (s_reg.cfg.bus_timer_run && s_reg.bus_busy) begin
				s_next.timer = full_sum[9:0];
				if (low_sum[3])
					s_next.min_ok = 1'b1;
				if (full_sum[10])
					ev_set.timeout = 1'b1;
			end else begin
				s_next.timer[2:0] = low_sum[2:0];
				if (low_sum[3])
					s_next.min_ok = 1'b1;
			end
		end

		// Bus state
		if (start_cond) begin
			s_next.bus_busy = 1'b1;
			s_next.start_det = 1'b1;
			ev_set.start = 1'b1;
		end
		if (stop_cond) begin
			s_next.bus_busy = 1'b0;
			s_next.stop_det = 1'b1;
			ev_set.stop = 1'b1;
		end
		if (enabled && scl && !scl_prev) begin
			s_next.data_ready_set = 1'b1;
			ev_set.data_ready = 1'b1;
		end
		if (ev_set.timeout) begin
			s_next.bus_busy = 1'b0;
			s_next.timer = '0;
			s_next.cfg.target_enable = 1'b0;
		end


		// Controller role
		// A request during a busy frame waits until a stop or a bus time-out frees the bus.
		// A release armed by a stop command takes effect at the stop itself.
		if (send_stop_cmd && !s_reg.cfg.master_request)
			s_next.release_pending = 1'b1;
		if (arbitration_lost) begin
			s_next.is_controller = 1'b0;
			s_next.release_pending = 1'b0;
		end else if (s_reg.release_pending && stop_cond) begin
			s_next.is_controller = 1'b0;
			s_next.release_pending = 1'b0;
		end else if (s_reg.cfg.master_request && !s_reg.bus_busy && !start_cond) begin
			s_next.is_controller = 1'b1;
		end


		// SCL drive: stretching and controller phase timing
		// A pending bit event holds SCL low; the hold is only started while
		// SCL is already low, so a high phase is never cut short.
		if (!enabled) begin
			s_next.scl_oe = 1'b0;
		end else if (s_reg.is_controller) begin
			if (scl && !s_reg.scl_oe)
				s_next.scl_oe = s_reg.min_ok && s_reg.bus_busy;
			else
				s_next.scl_oe = !(s_reg.min_ok && !event_pending);
		end else begin
			s_next.scl_oe = event_pending && (s_reg.scl_oe || !scl);
		end

		// SDA follows the transmit bit only during SCL low
		if (!enabled)
			s_next.sda_oe = 1'b0;
		else if (!scl)
			s_next.sda_oe = transmit_active && !transmit_bit;


		// Register bus
		// Address and data are captured independently and the write is done
		// once both are held; the response waits for its ready before the
		// next write may be taken. Only byte lane zero carries register bits.
		if (s_reg.axi.awready && s_axi_awvalid) begin
			s_next.axi.aw_have = 1'b1;
			s_next.axi.aw_addr = s_axi_awaddr;
		end
		if (s_reg.axi.wready && s_axi_wvalid) begin
			s_next.axi.w_have = 1'b1;
			s_next.axi.wdata = s_axi_wdata;
			s_next.axi.wstrb = s_axi_wstrb;
		end
		if (s_reg.axi.bvalid && s_axi_bready)
			s_next.axi.bvalid = 1'b0;
		do_write = s_reg.axi.aw_have && s_reg.axi.w_have && !s_reg.axi.bvalid;
		wbyte = s_reg.axi.wdata[7:0];
		if (do_write) begin
			s_next.axi.aw_have = 1'b0;
			s_next.axi.w_have = 1'b0;
			s_next.axi.bvalid = 1'b1;
			s_next.axi.bresp = mapped(s_reg.axi.aw_addr) ? `IBW_RESP_OKAY : `IBW_RESP_SLVERR;
			if (s_reg.axi.wstrb[0]) begin
				case (s_reg.axi.aw_addr)
					`IBW_OFS_CONFIG: begin
						if (!ev_set.timeout)
							s_next.cfg.target_enable = wbyte[`IBW_CFG_TARGET_EN];
						s_next.cfg.master_request = wbyte[`IBW_CFG_MASTER_REQ];
						s_next.cfg.bus_timer_run = wbyte[`IBW_CFG_TIMER_RUN];
						s_next.cfg.min_time_select = {wbyte[`IBW_CFG_MTS_HI],
						                              wbyte[`IBW_CFG_MTS_LO]};
						clr_timeout = wbyte[`IBW_CFG_CLR_TIMEOUT];
					end
					`IBW_OFS_IRQ_STATUS: ev_clr = wbyte[3:0];
					`IBW_OFS_IRQ_MASK:   s_next.mask = wbyte[3:0];
					default: ;
				endcase
			end
		end
		if (clr_timeout)
			ev_clr.timeout = 1'b1;
		s_next.status = (s_reg.status & ~ev_clr) | ev_set;

		if (s_reg.axi.rvalid && s_axi_rready)
			s_next.axi.rvalid = 1'b0;
		if (s_reg.axi.arready && s_axi_arvalid) begin
			s_next.axi.rvalid = 1'b1;
			s_next.axi.rdata = read_word(s_reg, s_axi_araddr);
			s_next.axi.rresp = mapped(s_axi_araddr) ? `IBW_RESP_OKAY : `IBW_RESP_SLVERR;
		end
		s_next.axi.awready = !s_next.axi.aw_have && !s_next.axi.bvalid;
		s_next.axi.wready = !s_next.axi.w_have && !s_next.axi.bvalid;
		s_next.axi.arready = !s_next.axi.rvalid;

		s_next.irq = |(s_next.status & s_next.mask);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
			s_reg.cfg <= ibw_pkg::ibw_config_type'(`IBW_CONFIG_RESET);
			s_reg.mask <= `IBW_MASK_RESET;
			s_reg.scl_sync <= 3'h7;
			s_reg.sda_sync <= 3'h7;
		end else begin
			s_reg <= s_next;
		end
	end

	// Every output except scl_out and sda_out comes straight from the state register
	assign s_axi_awready = s_reg.axi.awready;
	assign s_axi_wready = s_reg.axi.wready;
	assign s_axi_bvalid = s_reg.axi.bvalid;
	assign s_axi_bresp = s_reg.axi.bresp;
	assign s_axi_arready = s_reg.axi.arready;
	assign s_axi_rvalid = s_reg.axi.rvalid;
	assign s_axi_rdata = s_reg.axi.rdata;
	assign s_axi_rresp = s_reg.axi.rresp;

	// Open-drain pins: the value is always low, the enable does the work
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = s_reg.scl_oe;
	assign sda_oe = s_reg.sda_oe;
	assign data_ready_set = s_reg.data_ready_set;
	assign start_det = s_reg.start_det;
	assign stop_det = s_reg.stop_det;
	assign is_controller = s_reg.is_controller;
	assign bus_busy = s_reg.bus_busy;
	assign min_time_ok = s_reg.min_ok;
	assign irq = s_reg.irq;

endmodule

// ===== logic/ibw_map.svh
// Register offsets, field positions, reset values and timing counts of the bit timing block
`ifndef IBW_MAP_SVH
`define IBW_MAP_SVH

`define IBW_ADDR_W          8
`define IBW_OFS_CONFIG      8'h00
`define IBW_OFS_IRQ_STATUS  8'h04
`define IBW_OFS_IRQ_MASK    8'h08
`define IBW_OFS_STATE       8'h0C

`define IBW_CFG_TARGET_EN   7
`define IBW_CFG_MASTER_REQ  6
`define IBW_CFG_CLR_TIMEOUT 5
`define IBW_CFG_TIMER_RUN   4
`define IBW_CFG_MTS_HI      1
`define IBW_CFG_MTS_LO      0
`define IBW_CONFIG_RESET    8'h00
`define IBW_MASK_RESET      4'h0

`define IBW_EV_DATA_READY   0
`define IBW_EV_TIMEOUT      1
`define IBW_EV_START        2
`define IBW_EV_STOP         3

`define IBW_STATE_CTRL      0
`define IBW_STATE_BUSY      1
`define IBW_STATE_MIN_OK    2
`define IBW_STATE_TIMER_LSB 16

`define IBW_MC_CLOCKS       6
`define IBW_RELOAD_BASE     10'h008
`define IBW_TIMER_W         10
`define IBW_MIN_COUNT_10    4'h7
`define IBW_MIN_COUNT_01    4'h6
`define IBW_MIN_COUNT_00    4'h5
`define IBW_MIN_COUNT_11    4'h4

`define IBW_RESP_OKAY       2'h0
`define IBW_RESP_SLVERR     2'h2

`endif

// ===== logic/ibw_pkg.sv
// Types shared by the bit timing and bus watch block
package ibw_pkg;

	typedef struct packed {
		logic       target_enable;
		logic       master_request;
		logic       bus_timer_run;
		logic [1:0] min_time_select;
	} ibw_config_type;

	// Order matches the event bit positions: stop, start, timeout, data ready
	typedef struct packed {
		logic stop;
		logic start;
		logic timeout;
		logic data_ready;
	} ibw_events_type;

	typedef struct packed {
		logic        aw_have;
		logic        w_have;
		logic [7:0]  aw_addr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} ibw_axi_type;

	typedef struct packed {
		ibw_config_type cfg;
		ibw_events_type status;
		ibw_events_type mask;
		logic [2:0]     scl_sync;
		logic [2:0]     sda_sync;
		logic [2:0]     mc_div;
		logic [9:0]     timer;
		logic           min_ok;
		logic           bus_busy;
		logic           is_controller;
		logic           release_pending;
		logic           scl_oe;
		logic           sda_oe;
		logic           data_ready_set;
		logic           start_det;
		logic           stop_det;
		logic           irq;
		ibw_axi_type    axi;
	} ibw_state_type;

endpackage

// ===== verification/ibw_bus_peer.sv
// Behavioural bus device that makes start, data bits and stop on the two-wire link
`timescale 1ns/10ps
module ibw_bus_peer (
	output logic     scl_pull, // High pulls SCL low
	output logic     sda_pull, // High pulls SDA low
	input wire logic scl_line  // Resolved SCL level
);
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end
	task automatic set_scl(input logic v);
		#7;
		scl_pull = v;
	endtask
	task automatic start();
		#7;
		sda_pull = 1'b1;
		#80;
		scl_pull = 1'b1;
		#80;
	endtask
	// Waits out any stretch of the low phase before the high phase starts
	task automatic bitc(input logic b);
		#7;
		sda_pull = !b;
		#80;
		scl_pull = 1'b0;
		wait (scl_line === 1'b1);
		#80;
		scl_pull = 1'b1;
		#40;
		sda_pull = 1'b0;
		#40;
	endtask
	task automatic stop();
		#7;
		sda_pull = 1'b1;
		#80;
		scl_pull = 1'b0;
		wait (scl_line === 1'b1);
		#80;
		sda_pull = 1'b0;
		#80;
	endtask
endmodule

// ===== verification/ibw_bit_timing_properties.sv
// Concurrent checks on the ports of the bit timing block
`timescale 1ns/10ps
module ibw_bit_timing_properties (
	input wire logic        aclk,             // Clock
	input wire logic        aresetn,          // Reset, active low
	input wire logic        s_axi_awvalid,    // AW valid
	input wire logic        s_axi_awready,    // AW ready
	input wire logic        s_axi_wvalid,     // W valid
	input wire logic        s_axi_wready,     // W ready
	input wire logic [1:0]  s_axi_bresp,      // B response
	input wire logic        s_axi_bvalid,     // B valid
	input wire logic        s_axi_bready,     // B ready
	input wire logic        s_axi_arvalid,    // AR valid
	input wire logic        s_axi_arready,    // AR ready
	input wire logic [31:0] s_axi_rdata,      // R data
	input wire logic        s_axi_rvalid,     // R valid
	input wire logic        s_axi_rready,     // R ready
	input wire logic        scl_in,           // SCL level
	input wire logic        scl_oe,           // SCL pull
	input wire logic        sda_oe,           // SDA pull
	input wire logic        transmit_bit,     // Bit to send
	input wire logic        transmit_active,  // Send allowed
	input wire logic        event_pending,    // Event unserviced
	input wire logic        arbitration_lost, // Loss pulse
	input wire logic        data_ready_set,   // Data ready pulse
	input wire logic        stop_det,         // Stop pulse
	input wire logic        is_controller,    // Controller role
	input wire logic        bus_busy          // Frame in progress
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_wr_answer;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	property p_wr_latency;
		s_wr_taken |=> s_wr_answer;
	endproperty
	a_wr_latency: assert property (p_wr_latency) else $error("write answer late");
	property p_rd_latency;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_rd_latency: assert property (p_rd_latency) else $error("read answer late");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_stretch;
		scl_oe && event_pending && !arbitration_lost |=> scl_oe;
	endproperty
	a_stretch: assert property (p_stretch) else $error("stretch ended early");
	property p_sda_rise;
		$rose(sda_oe) |-> $past(transmit_active) && !$past(transmit_bit);
	endproperty
	a_sda_rise: assert property (p_sda_rise) else $error("sda pulled wrongly");
	property p_sda_still;
		scl_in && $past(scl_in) && $past(scl_in, 2) && $past(scl_in, 3) |-> $stable(sda_oe);
	endproperty
	a_sda_still: assert property (p_sda_still) else $error("sda moved in high");
	property p_data_ready_flag;
		data_ready_set |-> ($past(scl_in, 3) && !$past(scl_in, 4)) ##1 !data_ready_set;
	endproperty
	a_data_ready_flag: assert property (p_data_ready_flag) else $error("data ready off edge");
	property p_take_idle;
		$rose(is_controller) |-> !$past(bus_busy);
	endproperty
	a_take_idle: assert property (p_take_idle) else $error("role taken busy");
	property p_stop_frees;
		stop_det |-> ##[0:1] !bus_busy;
	endproperty
	a_stop_frees: assert property (p_stop_frees) else $error("busy after stop");
	property p_arb_drop;
		arbitration_lost |=> !is_controller;
	endproperty
	a_arb_drop: assert property (p_arb_drop) else $error("role kept on loss");
endmodule
bind ibw_bit_timing ibw_bit_timing_properties u_props (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .scl_in(scl_in),
	.scl_oe(scl_oe), .sda_oe(sda_oe), .transmit_bit(transmit_bit),
	.transmit_active(transmit_active), .event_pending(event_pending),
	.arbitration_lost(arbitration_lost), .data_ready_set(data_ready_set),
	.stop_det(stop_det), .is_controller(is_controller), .bus_busy(bus_busy)
);

// ===== verification/ibw_bit_timing_bench.sv
// Self-checking bench of the bit timing and bus watch block
`timescale 1ns/10ps
`include "ibw_map.svh"
module ibw_bit_timing_bench;
	logic        aclk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        scl_in, sda_in, scl_oe, sda_oe, data_ready_set, start_det, stop_det;
	logic        is_controller, bus_busy, min_time_ok, irq, peer_scl, peer_sda;
	logic        aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, transmit_bit = 1'b1;
	logic        transmit_active = 1'b0, event_pending = 1'b0, arbitration_lost = 1'b0;
	logic        send_stop_cmd = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [33:0] exp_q[$];
	int          bad_count = 0, comparisons = 0, n, lo;
	int          n_start = 0, n_stop = 0, n_data_ready_flag = 0;
	int          mc[4] = '{`IBW_MIN_COUNT_00, `IBW_MIN_COUNT_01, `IBW_MIN_COUNT_10, `IBW_MIN_COUNT_11};
	int          tmo = (1024 - (8 - `IBW_MIN_COUNT_11)) * `IBW_MC_CLOCKS;
	ibw_bit_timing u_dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .scl_in(scl_in), .scl_out(), .scl_oe(scl_oe),
		.sda_in(sda_in), .sda_out(), .sda_oe(sda_oe), .transmit_bit(transmit_bit),
		.transmit_active(transmit_active), .event_pending(event_pending),
		.arbitration_lost(arbitration_lost), .send_stop_cmd(send_stop_cmd),
		.data_ready_set(data_ready_set), .start_det(start_det), .stop_det(stop_det),
		.is_controller(is_controller), .bus_busy(bus_busy), .min_time_ok(min_time_ok), .irq(irq)
	);
	ibw_bus_peer u_peer (.scl_pull(peer_scl), .sda_pull(peer_sda), .scl_line(scl_in));
	// Open-drain wires with pull-ups
	assign scl_in = !(scl_oe === 1'b1 || peer_scl === 1'b1);
	assign sda_in = !(sda_oe === 1'b1 || peer_sda === 1'b1);
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	task automatic report_and_stop();
		if (bad_count == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge aclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		s_axi_bready <= 1'b0;
		chk(34'(s_axi_bresp), 34'(r));
	endtask
	// Expected word is queued here and compared by the read monitor
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		exp_q.push_back({r, e});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		s_axi_rready <= 1'b0;
	endtask
	always @(posedge aclk) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && exp_q.size() > 0) begin
			chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
		end
	end
	always @(posedge aclk) begin
		if (start_det === 1'b1) n_start++;
		if (stop_det === 1'b1) n_stop++;
		if (data_ready_set === 1'b1) n_data_ready_flag++;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		report_and_stop();
	end
	initial begin
		void'($urandom(32'h367A935C));
		cyc(6);
		aresetn <= 1'b1;
		cyc(1);
		rd(`IBW_OFS_CONFIG, 32'h0, `IBW_RESP_OKAY);
		rd(`IBW_OFS_IRQ_STATUS, 32'h0, `IBW_RESP_OKAY);
		rd(8'h10, 32'h0, `IBW_RESP_SLVERR);
		wr(8'h14, 8'hFF, `IBW_RESP_SLVERR);
		wr(`IBW_OFS_CONFIG, 8'hBC, `IBW_RESP_OKAY);
		rd(`IBW_OFS_CONFIG, 32'h90, `IBW_RESP_OKAY);
		for (int s = 0; s < 4; s++) begin
			wr(`IBW_OFS_CONFIG, 8'h80 | 8'(s), `IBW_RESP_OKAY);
			u_peer.set_scl(1'b1);
			for (n = 1; n < 80; n++) begin
				@(posedge aclk);
				if (n > 5 && min_time_ok === 1'b1) break;
			end
			lo = mc[s] * `IBW_MC_CLOCKS - 2;
			chk(34'(n >= lo && n <= lo + 7), 34'h1);
			u_peer.set_scl(1'b0);
			cyc(60);
		end
		wr(`IBW_OFS_IRQ_MASK, 8'h0F, `IBW_RESP_OKAY);
		wr(`IBW_OFS_IRQ_STATUS, 8'h0F, `IBW_RESP_OKAY);
		rd(`IBW_OFS_IRQ_STATUS, 32'h0, `IBW_RESP_OKAY);
		chk(34'(irq), 34'h0);
		transmit_active <= 1'b1;
		u_peer.start();
		for (int k = 0; k < 3; k++) begin
			cyc(1);
			transmit_bit <= 1'($urandom);
			u_peer.bitc(1'($urandom));
		end
		cyc(1);
		event_pending <= 1'b1;
		fork
			u_peer.bitc(1'b1);
			begin
				cyc(40);
				chk(34'(scl_in), 34'h0);
				event_pending <= 1'b0;
			end
		join
		cyc(1);
		rd(`IBW_OFS_IRQ_STATUS, 32'h5, `IBW_RESP_OKAY);
		chk(34'(irq), 34'h1);
		wr(`IBW_OFS_IRQ_STATUS, 8'h05, `IBW_RESP_OKAY);
		rd(`IBW_OFS_IRQ_STATUS, 32'h0, `IBW_RESP_OKAY);
		chk(34'(irq), 34'h0);
		wr(`IBW_OFS_CONFIG, 8'hC0, `IBW_RESP_OKAY);
		transmit_active <= 1'b0;
		cyc(10);
		chk(34'(is_controller), 34'h0);
		u_peer.stop();
		cyc(10);
		chk(34'(is_controller), 34'h1);
		wr(`IBW_OFS_CONFIG, 8'h80, `IBW_RESP_OKAY);
		arbitration_lost <= 1'b1;
		cyc(1);
		arbitration_lost <= 1'b0;
		cyc(2);
		chk(34'(is_controller), 34'h0);
		wr(`IBW_OFS_IRQ_STATUS, 8'h0F, `IBW_RESP_OKAY);
		wr(`IBW_OFS_CONFIG, 8'h93, `IBW_RESP_OKAY);
		u_peer.start();
		cyc(tmo - 30);
		rd(`IBW_OFS_IRQ_STATUS, 32'h4, `IBW_RESP_OKAY);
		cyc(60);
		rd(`IBW_OFS_IRQ_STATUS, 32'h6, `IBW_RESP_OKAY);
		chk(34'(irq), 34'h1);
		rd(`IBW_OFS_CONFIG, 32'h13, `IBW_RESP_OKAY);
		wr(`IBW_OFS_CONFIG, 8'h33, `IBW_RESP_OKAY);
		rd(`IBW_OFS_IRQ_STATUS, 32'h4, `IBW_RESP_OKAY);
		u_peer.stop();
		cyc(6);
		chk(34'(bus_busy), 34'h0);
		chk(34'(n_start), 34'h2);
		chk(34'(n_stop), 34'h2);
		chk(34'(n_data_ready_flag), 34'h9);
		report_and_stop();
	end
endmodule
